// ==== rtl/dma_desc_loop.sv ====
// Descriptor address and loop counter engine for one channel
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dma_desc_loop
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic [4:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_minor_done,
    output logic [31:0]      o_rdata,
    output logic [31:0]      o_src_ptr,
    output logic [31:0]      o_dst_ptr,
    output logic             o_major_done,
    output logic [15:0]      o_link_start,
    output logic             o_desc_load_req,
    output logic [31:0]      o_desc_load_addr,
    output logic             o_cfg_err,
    output logic             o_irq
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [31:0] src_ptr;
        logic [15:0] src_step;
        logic [31:0] src_last;
        logic [31:0] dst_ptr;
        logic [15:0] dst_step;
        logic [31:0] dst_last;
        logic [15:0] cur_iter;
        logic [15:0] beg_iter;
        logic        sg_en;
        logic [31:0] rdata;
        logic        major_done;
        logic [15:0] link_start;
        logic        desc_load_req;
        logic [31:0] desc_load_addr;
        logic        cfg_err;
        logic [dma_desc_pkg::INT_W-1:0] int_status;
        logic [dma_desc_pkg::INT_W-1:0] int_mask;
        logic        irq;
    } state_t;

    state_t st;
    state_t next_st;

    logic        cur_link_en;
    logic [5:0]  cur_link_ch;
    logic [15:0] dec_iter;
    logic        last_minor;
    logic        beg_link_en;
    logic        link_mismatch;
    logic        link_ch_bad;
    logic        sg_misaligned;
    logic [dma_desc_pkg::INT_W-1:0] events;

    // Sign-extended, wrapping address step
    function automatic logic [31:0] add_step(input logic [31:0] base, input logic [15:0] step);
        add_step = base + {{16{step[15]}}, step};
    endfunction

    // ************************************************************
    // Counter decode
    // ************************************************************
    dma_iter_calc u_iter
    (
        .i_cur_iter (st.cur_iter),
        .o_link_en  (cur_link_en),
        .o_link_ch  (cur_link_ch),
        .o_dec_iter (dec_iter),
        .o_last     (last_minor)
    );

    // Configuration checks
    always_comb
    begin
        beg_link_en   = st.beg_iter[dma_desc_pkg::ITER_LINK_EN_BIT];
        link_mismatch = cur_link_en != beg_link_en;
        link_ch_bad   = cur_link_en && (cur_link_ch[5:4] != dma_desc_pkg::LINK_CH_VALID_TOP);
        sg_misaligned = st.sg_en && ((st.dst_last[4:0] & dma_desc_pkg::DESC_ALIGN_MASK) != 5'h00);
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        events = '0;
        next_st.major_done = 1'b0;
        next_st.link_start = '0;
        next_st.desc_load_req = 1'b0;
        next_st.cfg_err = link_mismatch || link_ch_bad || sg_misaligned;
        // Register writes
        if (i_wr)
        begin
            unique case (i_addr)
                dma_desc_pkg::ADDR_SRC_PTR:  next_st.src_ptr = i_wdata;
                dma_desc_pkg::ADDR_SRC_STEP: next_st.src_step = i_wdata[15:0];
                dma_desc_pkg::ADDR_SRC_LAST: next_st.src_last = i_wdata;
                dma_desc_pkg::ADDR_DST_PTR:  next_st.dst_ptr = i_wdata;
                dma_desc_pkg::ADDR_DST_STEP: next_st.dst_step = i_wdata[15:0];
                dma_desc_pkg::ADDR_DST_LAST: next_st.dst_last = i_wdata;
                dma_desc_pkg::ADDR_CUR_ITER: next_st.cur_iter = i_wdata[15:0];
                dma_desc_pkg::ADDR_BEG_ITER: next_st.beg_iter = i_wdata[15:0];
                dma_desc_pkg::ADDR_CTRL:     next_st.sg_en = i_wdata[dma_desc_pkg::CTRL_SG_BIT];
                dma_desc_pkg::ADDR_INT_MASK: next_st.int_mask = i_wdata[dma_desc_pkg::INT_W-1:0];
                default:                     next_st.sg_en = st.sg_en;
            endcase
        end
        // Loop progress; a config error blocks updates so a bad descriptor moves nothing
        if (i_minor_done && !next_st.cfg_err)
        begin
            events[dma_desc_pkg::INT_MINOR_BIT] = 1'b1;
            next_st.src_ptr = add_step(st.src_ptr, st.src_step);
            next_st.dst_ptr = add_step(st.dst_ptr, st.dst_step);
            // count down in the active width
            next_st.cur_iter = dec_iter;
            if (cur_link_en)
            begin
                next_st.link_start[cur_link_ch[3:0]] = 1'b1;
            end
            if (last_minor)
            begin
                events[dma_desc_pkg::INT_MAJOR_BIT] = 1'b1;
                next_st.major_done = 1'b1;
                next_st.src_ptr = add_step(st.src_ptr, st.src_step) + st.src_last;
                next_st.cur_iter = st.beg_iter;
                if (st.sg_en)
                begin
                    events[dma_desc_pkg::INT_SG_BIT] = 1'b1;
                    next_st.desc_load_req = 1'b1;
                    next_st.desc_load_addr = st.dst_last;
                end
                else
                begin
                    next_st.dst_ptr = add_step(st.dst_ptr, st.dst_step) + st.dst_last;
                end
            end
        end
        if (next_st.cfg_err && !st.cfg_err)
        begin
            events[dma_desc_pkg::INT_CFGERR_BIT] = 1'b1;
        end
        // Read data for the next cycle; status read clears, new events win
        next_st.rdata = dma_desc_pkg::RST_WORD;
        if (i_rd)
        begin
            unique case (i_addr)
                dma_desc_pkg::ADDR_SRC_PTR:    next_st.rdata = st.src_ptr;
                dma_desc_pkg::ADDR_SRC_STEP:   next_st.rdata = {16'h0000, st.src_step};
                dma_desc_pkg::ADDR_SRC_LAST:   next_st.rdata = st.src_last;
                dma_desc_pkg::ADDR_DST_PTR:    next_st.rdata = st.dst_ptr;
                dma_desc_pkg::ADDR_DST_STEP:   next_st.rdata = {16'h0000, st.dst_step};
                dma_desc_pkg::ADDR_DST_LAST:   next_st.rdata = st.dst_last;
                dma_desc_pkg::ADDR_CUR_ITER:   next_st.rdata = {16'h0000, st.cur_iter};
                dma_desc_pkg::ADDR_BEG_ITER:   next_st.rdata = {16'h0000, st.beg_iter};
                dma_desc_pkg::ADDR_CTRL:       next_st.rdata = {31'h0, st.sg_en};
                dma_desc_pkg::ADDR_STATUS:     next_st.rdata = {30'h0, st.cfg_err, cur_link_en};
                dma_desc_pkg::ADDR_INT_STATUS:
                begin
                    next_st.rdata = {28'h0, st.int_status};
                    next_st.int_status = '0;
                end
                dma_desc_pkg::ADDR_INT_MASK:   next_st.rdata = {28'h0, st.int_mask};
                dma_desc_pkg::ADDR_NEXT_DESC:  next_st.rdata = st.desc_load_addr;
                default:                       next_st.rdata = dma_desc_pkg::RST_WORD;
            endcase
        end
        next_st.int_status = next_st.int_status | events;
        next_st.irq = |(next_st.int_status & next_st.int_mask);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset wins over the clock enable; a low enable freezes all other state
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
        end
        else if (i_ce)
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign o_rdata          = st.rdata;
    assign o_src_ptr        = st.src_ptr;
    assign o_dst_ptr        = st.dst_ptr;
    assign o_major_done     = st.major_done;
    assign o_link_start     = st.link_start;
    assign o_desc_load_req  = st.desc_load_req;
    assign o_desc_load_addr = st.desc_load_addr;
    assign o_cfg_err        = st.cfg_err;
    assign o_irq            = st.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_minor_src_step;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && i_minor_done && !last_minor && !next_st.cfg_err && !i_wr) |=>
            (o_src_ptr == $past(st.src_ptr) + {{16{$past(st.src_step[15])}}, $past(st.src_step)});
    endproperty
    a_minor_src_step: assert property (p_minor_src_step) else $error("source step wrong");

    property p_minor_dst_step;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && i_minor_done && !last_minor && !next_st.cfg_err && !i_wr) |=>
            (o_dst_ptr == $past(st.dst_ptr) + {{16{$past(st.dst_step[15])}}, $past(st.dst_step)});
    endproperty
    a_minor_dst_step: assert property (p_minor_dst_step) else $error("destination step wrong");

    property p_reload;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && i_minor_done && last_minor && !next_st.cfg_err && !i_wr) |=>
            (st.cur_iter == $past(st.beg_iter)) && o_major_done;
    endproperty
    a_reload: assert property (p_reload) else $error("count not reloaded");

    property p_link;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && i_minor_done && !next_st.cfg_err && cur_link_en) |=> o_link_start[$past(cur_link_ch[3:0])];
    endproperty
    a_link: assert property (p_link) else $error("link start missing");

    property p_no_link;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && !cur_link_en) |=> (o_link_start == 16'h0000);
    endproperty
    a_no_link: assert property (p_no_link) else $error("unexpected link");

    property p_mismatch;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && link_mismatch) |=> o_cfg_err;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

    property p_sg_load;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && o_major_done && st.sg_en && !$past(i_wr)) |-> o_desc_load_req && (o_desc_load_addr == st.dst_last);
    endproperty
    a_sg_load: assert property (p_sg_load) else $error("descriptor load missing");

    property p_decrement;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && i_minor_done && !last_minor && !next_st.cfg_err && !i_wr) |=> (st.cur_iter != $past(st.cur_iter));
    endproperty
    a_decrement: assert property (p_decrement) else $error("count did not move");

    property p_major_src_adjust;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && i_minor_done && last_minor && !next_st.cfg_err && !i_wr) |=>
            (o_src_ptr == $past(st.src_ptr) + {{16{$past(st.src_step[15])}}, $past(st.src_step)}
                + $past(st.src_last));
    endproperty
    a_major_src_adjust: assert property (p_major_src_adjust) else $error("source last adjust wrong");

    property p_major_dst_adjust;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && i_minor_done && last_minor && !next_st.cfg_err && !i_wr && !st.sg_en) |=>
            (o_dst_ptr == $past(st.dst_ptr) + {{16{$past(st.dst_step[15])}}, $past(st.dst_step)}
                + $past(st.dst_last));
    endproperty
    a_major_dst_adjust: assert property (p_major_dst_adjust) else $error("destination last adjust wrong");

    property p_reserved_channel;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && link_ch_bad) |=> o_cfg_err;
    endproperty
    a_reserved_channel: assert property (p_reserved_channel) else $error("reserved channel not flagged");

    property p_error_freezes;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && next_st.cfg_err && !i_wr) |=> $stable(o_src_ptr) && $stable(o_dst_ptr);
    endproperty
    a_error_freezes: assert property (p_error_freezes) else $error("pointers moved under error");
endmodule // dma_desc_loop
`default_nettype wire

// ==== rtl/dma_desc_pkg.sv ====
// Constants for the descriptor loop control block
package dma_desc_pkg;
    // Register word addresses (plain port, word indexed)
    localparam logic [4:0] ADDR_SRC_PTR      = 5'h00;
    localparam logic [4:0] ADDR_SRC_STEP     = 5'h01;
    localparam logic [4:0] ADDR_SRC_LAST     = 5'h02;
    localparam logic [4:0] ADDR_DST_PTR      = 5'h03;
    localparam logic [4:0] ADDR_DST_STEP     = 5'h04;
    localparam logic [4:0] ADDR_DST_LAST     = 5'h05;
    localparam logic [4:0] ADDR_CUR_ITER     = 5'h06;
    localparam logic [4:0] ADDR_BEG_ITER     = 5'h07;
    localparam logic [4:0] ADDR_CTRL         = 5'h08;
    localparam logic [4:0] ADDR_STATUS       = 5'h09;
    localparam logic [4:0] ADDR_INT_STATUS   = 5'h0A;
    localparam logic [4:0] ADDR_INT_MASK     = 5'h0B;
    localparam logic [4:0] ADDR_NEXT_DESC    = 5'h0C;
    // Iteration word layout: bit 15 link enable, 14:9 link channel, 8:0 short count
    localparam int ITER_LINK_EN_BIT = 15;
    localparam int ITER_LINK_CH_HI  = 14;
    localparam int ITER_LINK_CH_LO  = 9;
    localparam int ITER_SHORT_HI    = 8;
    localparam int ITER_LONG_HI     = 14;
    // Link channel field: upper two bits must be zero
    localparam logic [1:0] LINK_CH_VALID_TOP = 2'h0;
    // Control bit positions
    localparam int CTRL_SG_BIT = 0;
    // Interrupt status bits
    localparam int INT_MINOR_BIT  = 0;
    localparam int INT_MAJOR_BIT  = 1;
    localparam int INT_CFGERR_BIT = 2;
    localparam int INT_SG_BIT     = 3;
    localparam int INT_W          = 4;
    // Descriptors must sit on 32-byte boundaries
    localparam logic [4:0] DESC_ALIGN_MASK = 5'h1F;
    // Reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [15:0] RST_HALF  = 16'h0000;
    localparam int NUM_CHANNELS = 16;
endpackage

// ==== rtl/dma_iter_calc.sv ====
// Iteration counter decode and decrement for one descriptor
`timescale 1ns/1ps
`default_nettype none
module dma_iter_calc
(
    input  wire logic [15:0] i_cur_iter,
    output logic             o_link_en,
    output logic [5:0]       o_link_ch,
    output logic [15:0]      o_dec_iter,
    output logic             o_last
);
    // Field split depends on the link enable in the same word
    always_comb
    begin
        o_link_en = i_cur_iter[dma_desc_pkg::ITER_LINK_EN_BIT];
        o_link_ch = i_cur_iter[dma_desc_pkg::ITER_LINK_CH_HI:dma_desc_pkg::ITER_LINK_CH_LO];
        o_dec_iter = i_cur_iter;
        if (o_link_en)
        begin
            // 9-bit count below a 6-bit channel
            o_dec_iter[dma_desc_pkg::ITER_SHORT_HI:0] = i_cur_iter[dma_desc_pkg::ITER_SHORT_HI:0] - 9'h001;
            o_last = (i_cur_iter[dma_desc_pkg::ITER_SHORT_HI:0] <= 9'h001);
        end
        else
        begin
            // Full 15-bit count
            o_dec_iter[dma_desc_pkg::ITER_LONG_HI:0] = i_cur_iter[dma_desc_pkg::ITER_LONG_HI:0] - 15'h0001;
            o_last = (i_cur_iter[dma_desc_pkg::ITER_LONG_HI:0] <= 15'h0001);
        end
    end
endmodule // dma_iter_calc
`default_nettype wire

// ==== testbench/dma_mem_partner.sv ====
// Far-side model: memory engine that runs minor loops and fetches descriptors
`timescale 1ns/1ps
`default_nettype none
module dma_mem_partner
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_kick,
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_desc_load_req,
    input  wire logic [31:0] i_desc_load_addr,
    output logic             o_minor_done,
    output logic [31:0]      o_fetch_addr
);
    logic [4:0] cnt;

    // Minor loop ends after a chosen delay, prompt or slow; one-cycle pulse
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            cnt          <= 5'h00;
            o_minor_done <= 1'b0;
            o_fetch_addr <= 32'h0000_0000;
        end
        else
        begin
            o_minor_done <= (cnt == 5'h01);
            if (i_kick)
                cnt <= {1'b0, i_delay} + 5'h01;
            else if (cnt != 5'h00)
                cnt <= cnt - 5'h01;
            if (i_desc_load_req)
                o_fetch_addr <= i_desc_load_addr;
        end
    end
endmodule // dma_mem_partner
`default_nettype wire

// ==== testbench/dma_descriptor_loop_control_tb_top.sv ====
// Self-checking bench for the descriptor loop control block
`timescale 1ns/1ps
`default_nettype none
module dma_descriptor_loop_control_tb_top;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        kick = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  delay = 4'h0;
    logic [4:0]  i_addr = 5'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [31:0] o_rdata, o_src_ptr, o_dst_ptr, o_desc_load_addr, fetch_addr;
    logic [15:0] o_link_start;
    logic        o_major_done, o_desc_load_req, o_cfg_err, o_irq, minor_done;
    logic [31:0] seed = 32'h18771F05;
    logic [31:0] rd, src, dst, ss, ds, sl, dl, it, cnt, lastv;
    logic [3:0]  ch;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;

    dma_desc_loop uut
    (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_minor_done(minor_done), .o_rdata(o_rdata),
        .o_src_ptr(o_src_ptr), .o_dst_ptr(o_dst_ptr), .o_major_done(o_major_done),
        .o_link_start(o_link_start), .o_desc_load_req(o_desc_load_req),
        .o_desc_load_addr(o_desc_load_addr), .o_cfg_err(o_cfg_err), .o_irq(o_irq)
    );
    dma_mem_partner far_side
    (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_kick(kick), .i_delay(delay),
        .i_desc_load_req(o_desc_load_req), .i_desc_load_addr(o_desc_load_addr),
        .o_minor_done(minor_done), .o_fetch_addr(fetch_addr)
    );

    // 100 MHz clock
    always #5 i_mclk = ~i_mclk;

    // Hang guard; the run needs a few thousand cycles at most
    always @(posedge i_mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            complete_run();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Signed 16-bit step widened to an address increment
    function automatic logic [31:0] sx(input logic [31:0] v);
        return {{16{v[15]}}, v[15:0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; read data captured in the following cycle only
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        i_wr <= w;
        i_rd <= ~w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1 rd = o_rdata;
    endtask

    // Ask the far side for one minor loop, return once its effects are visible
    task automatic minor();
        int n;
        n = 0;
        seed = xs(seed);
        delay <= seed[3:0];
        kick <= 1'b1;
        @(posedge i_mclk);
        kick <= 1'b0;
        #1;
        while (minor_done !== 1'b1 && n < 40)
        begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        @(posedge i_mclk);
        #1;
    endtask

    // Random descriptor; scatter/gather pointer kept aligned
    task automatic prog(input logic [31:0] cur, input logic [31:0] beg, input logic [31:0] ctl);
        logic [31:0] w [8];
        seed = xs(seed);
        src = seed;
        seed = xs(seed);
        dst = seed;
        seed = xs(seed);
        ss = {16'h0000, seed[15:0]};
        ds = {16'h0000, seed[31:16]};
        seed = xs(seed);
        sl = seed;
        seed = xs(seed);
        dl = ctl[0] ? {seed[31:5], 5'h00} : seed;
        w = '{src, ss, sl, dst, ds, dl, cur, beg};
        for (int a = 0; a < 8; a++)
            bus(1'b1, dma_desc_pkg::ADDR_SRC_PTR + 5'(a), w[a]);
        bus(1'b1, dma_desc_pkg::ADDR_CTRL, ctl);
        bus(1'b1, dma_desc_pkg::ADDR_INT_MASK, 32'h0000_0002);
        bus(1'b0, dma_desc_pkg::ADDR_INT_STATUS, 32'h0000_0000);
        @(posedge i_mclk);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        bus(1'b0, dma_desc_pkg::ADDR_DST_PTR, 32'h0000_0000);
        chk(rd, 32'h0000_0000); // cleared pointer
        bus(1'b0, 5'h1F, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test reset done");
        // Plain loops, most negative step first, then random
        for (int k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            cnt = {29'h0, seed[2:0]} + 32'h2;
            prog(cnt, cnt, 32'h0); // current equals beginning
            if (k == 0)
            begin
                ss = 32'h0000_8000;
                bus(1'b1, dma_desc_pkg::ADDR_SRC_STEP, ss);
            end
            for (int m = int'(cnt); m > 0; m--)
            begin
                minor();
                lastv = (m == 1) ? 32'h1 : 32'h0;
                src = src + sx(ss) + (m == 1 ? sl : 32'h0);
                dst = dst + sx(ds) + (m == 1 ? dl : 32'h0);
                chk(o_src_ptr, src);
                chk(o_dst_ptr, dst);
                chk(32'(o_major_done), lastv);
                chk(32'(o_link_start), 32'h0);
                chk(32'(o_irq), lastv);
                if (m == int'(cnt))
                begin
                    bus(1'b0, dma_desc_pkg::ADDR_CUR_ITER, 32'h0);
                    chk(rd, cnt - 32'h1);
                end
            end
            bus(1'b0, dma_desc_pkg::ADDR_CUR_ITER, 32'h0);
            chk(rd, cnt);
            bus(1'b0, dma_desc_pkg::ADDR_INT_STATUS, 32'h0);
            chk(rd, 32'h0000_0003);
            @(posedge i_mclk);
            #1;
            chk(32'(o_irq), 32'h0);
        end
        // Long count borrows across the link field boundary
        prog(32'h0200, 32'h0200, 32'h0);
        // Low clock enable: the minor end must leave the engine untouched
        ce <= 1'b0;
        minor();
        ce <= 1'b1;
        chk(o_src_ptr, src);
        minor();
        chk(o_src_ptr, src + sx(ss));
        bus(1'b0, dma_desc_pkg::ADDR_CUR_ITER, 32'h0);
        chk(rd, 32'h0000_01FF);
        $display("test plain done");
        // Minor linking to first, last and a random channel
        for (int k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            ch = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : seed[3:0];
            it = {16'h0000, 1'b1, 2'b00, ch, 9'h002};
            prog(it, it, 32'h0); // equal fields
            minor();
            chk(32'(o_link_start), 32'h1 << ch);
            bus(1'b0, dma_desc_pkg::ADDR_CUR_ITER, 32'h0);
            chk(rd, it - 32'h1);
            minor();
            chk(32'(o_major_done), 32'h1);
            bus(1'b0, dma_desc_pkg::ADDR_CUR_ITER, 32'h0);
            chk(rd, it);
        end
        $display("test link done");
        // Mismatched enables refuse loop events; reserved link channels raise the error
        prog(32'h8002, 32'h0002, 32'h0);
        chk(32'(o_cfg_err), 32'h1);
        minor();
        chk(o_dst_ptr, dst);
        bus(1'b0, dma_desc_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_0003);
        for (int t = 1; t < 4; t++)
        begin
            it = {16'h0000, 1'b1, 2'(t), 4'h3, 9'h002};
            prog(it, it, 32'h0);
            chk(32'(o_cfg_err), 32'h1);
        end
        $display("test config error done");
        // Scatter/gather single-minor major loop
        prog(32'h1, 32'h1, 32'h1); // aligned pointer
        minor();
        chk(o_src_ptr, src + sx(ss) + sl);
        chk(o_dst_ptr, dst + sx(ds));
        chk(32'(o_desc_load_req), 32'h1);
        chk(o_desc_load_addr, dl);
        @(posedge i_mclk);
        #1;
        chk(fetch_addr, dl);
        bus(1'b0, dma_desc_pkg::ADDR_NEXT_DESC, 32'h0);
        chk(rd, dl);
        bus(1'b1, dma_desc_pkg::ADDR_DST_LAST, dl + 32'h4);
        @(posedge i_mclk);
        #1;
        chk(32'(o_cfg_err), 32'h1);
        $display("test scatter gather done");
        // Mid-run reset clears pointers and the standing error
        i_rst_n <= 1'b0;
        @(posedge i_mclk);
        #1;
        chk(o_dst_ptr, 32'h0000_0000);
        chk(32'(o_cfg_err), 32'h0);
        chk(o_desc_load_addr, 32'h0000_0000);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        $display("test reset again done");
        complete_run();
    end
endmodule // dma_descriptor_loop_control_tb_top
`default_nettype wire
